// ---- verification/dss_platform_model.sv ----
// Platform model: chipset sleep request pins and a gated bus clock.
// Assumes a free-running clock and level sleep wishes from the bench.
`default_nettype none
module dss_platform_model (
   input wire logic freeClk,
   input wire logic goDeep,
   input wire logic goDeeper,
   input wire logic stopClk,
   output logic mclk,
   output var logic deep_sleep_req_n,
   output var logic deeper_sleep_req_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic clkOn = 1'h1;
   int cnt = 0;
   // ****************
   // Pins and clock
   // ****************
   initial {deep_sleep_req_n, deeper_sleep_req_n} = 2'h3;
   always @(negedge freeClk) begin
      deep_sleep_req_n <= !(goDeep || !deeper_sleep_req_n);
      deeper_sleep_req_n <= !(goDeeper && !deep_sleep_req_n);
      // Count from the deeper request, so the core sees that request before the clock stops.
      cnt <= deeper_sleep_req_n ? 0 : cnt + 1;
      clkOn <= !(stopClk && goDeeper && cnt >= 4);
   end
   // clock may run on. Gate moves while low, so no glitch.
   assign mclk = freeClk & clkOn;
endmodule
`default_nettype wire

// ---- verification/dss_sequencer_checker.sv ----
// Checker for the deep sleep state sequencer, bound to its ports.
// Assumes one bus clock domain with a synchronous active-high reset.
`default_nettype none
module dss_sequencer_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic lowPowerReq,
   input wire dss_pkg::dss_cstate_type lowPowerState,
   input wire logic promoteDeeper,
   input wire logic hard_extended_deeper_sleep_option,
   input wire logic breakEvent,
   input wire logic sleepEnter,
   input wire logic deep_sleep_req_n,
   input wire logic deeper_sleep_req_n,
   input wire logic [dss_pkg::VID_W-1:0] lowestVid,
   input wire logic [dss_pkg::VID_W-1:0] deeperVid,
   input wire logic [dss_pkg::VID_W-1:0] voltage_id_code,
   input wire logic [dss_pkg::PSTATE_W-1:0] currentPstate,
   input wire logic executing,
   input wire logic inDeepSleep,
   input wire logic inDeeperSleep,
   input wire logic extendedActive
);
   // ****************
   // Sequencing checks
   // ****************
   // Status flags lag the sampled request by two edges, hence the depth of two.
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   deep_entry_a: assert property ($rose(inDeepSleep) |-> $past(!deep_sleep_req_n && sleepEnter, 2))
      else $error("Deep sleep entered without request in sleep.");
   deep_is_deeper_a: assert property (inDeeperSleep |-> inDeepSleep)
      else $error("Deeper flag without deep flag.");
   deeper_entry_a: assert property ($rose(inDeeperSleep) |-> $past(inDeepSleep) && $past(!deeper_sleep_req_n, 2))
      else $error("Deeper sleep entered out of order.");
   deeper_vid_a: assert property ($rose(inDeeperSleep) |-> voltage_id_code == deeperVid)
      else $error("Deeper voltage code missing.");
   deeper_exit_a: assert property (inDeeperSleep && $past(deeper_sleep_req_n) && deeper_sleep_req_n |-> ##[1:2] !inDeeperSleep)
      else $error("Deeper sleep not left after release.");
   step_down_a: assert property ($rose(extendedActive) |-> currentPstate == dss_pkg::PSTATE_LOWEST)
      else $error("Extended entry above lowest point.");
   break_resume_a: assert property (extendedActive && breakEvent && !sleepEnter && !inDeepSleep |-> ##[1:3] executing)
      else $error("Break did not resume execution.");
   promote_a: assert property (lowPowerReq && executing && promoteDeeper && lowPowerState == dss_pkg::CST_DEEPER |-> ##[1:4] extendedActive)
      else $error("Promotion bit ignored.");
   pstate_frozen_a: assert property (inDeepSleep && $past(inDeepSleep) && !hard_extended_deeper_sleep_option |-> $stable(currentPstate))
      else $error("Operating point moved in deep sleep.");
   hard_exit_a: assert property ($fell(inDeeperSleep) && hard_extended_deeper_sleep_option |-> ##[0:2] (voltage_id_code == lowestVid && currentPstate == dss_pkg::PSTATE_LOWEST))
      else $error("Hard option exit not at lowest point.");
   deeper_c: cover property ($rose(inDeeperSleep));
   extended_c: cover property ($rose(extendedActive));
   hard_exit_c: cover property ($fell(inDeeperSleep) && hard_extended_deeper_sleep_option);
endmodule
bind dss_sequencer dss_sequencer_checker dss_sequencer_checker_inst (.mclk, .sys_rst, .lowPowerReq,
   .lowPowerState, .promoteDeeper, .hard_extended_deeper_sleep_option, .breakEvent, .sleepEnter,
   .deep_sleep_req_n, .deeper_sleep_req_n, .lowestVid, .deeperVid, .voltage_id_code,
   .currentPstate, .executing, .inDeepSleep, .inDeeperSleep, .extendedActive);
`default_nettype wire

// ---- verification/dss_sequencer_tb.sv ----
// Testbench for the deep sleep state sequencer with a platform model.
// Assumes the package, checker and platform model are compiled first.
`default_nettype none
module dss_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic freeClk = 1'h0, sys_rst = 1'h1, lowPowerReq = 1'h0, subStateHint = 1'h0;
   logic promoteHalt = 1'h0, promoteStopGrant = 1'h0, promoteDeeper = 1'h0, e;
   logic sleepEnter = 1'h0, breakEvent = 1'h0, hardOpt = 1'h0, stopClk = 1'h0;
   logic goDeep = 1'h0, goDeeper = 1'h0, mclk, deep_sleep_req_n, deeper_sleep_req_n;
   logic executing, inDeepSleep, inDeeperSleep, extendedActive;
   dss_pkg::dss_cstate_type lowPowerState = dss_pkg::CST_HALT;
   logic [3:0] requestedPstate = 4'h0, currentPstate;
   logic [6:0] activeVid = 7'h30, lowestVid = 7'h2A, deeperVid = 7'h15, voltage_id_code;
   int num_errors = 0, compares = 0, cycles = 0, n;
   dss_platform_model dss_platform_model_inst (.freeClk, .goDeep, .goDeeper, .stopClk, .mclk,
      .deep_sleep_req_n, .deeper_sleep_req_n);
   dss_sequencer dss_sequencer_inst (.mclk, .sys_rst, .lowPowerReq, .lowPowerState,
      .subStateHint, .promoteHalt, .promoteStopGrant, .promoteDeeper,
      .hard_extended_deeper_sleep_option(hardOpt), .breakEvent, .sleepEnter,
      .deep_sleep_req_n, .deeper_sleep_req_n, .requestedPstate, .activeVid, .lowestVid,
      .deeperVid, .voltage_id_code, .currentPstate, .executing, .inDeepSleep,
      .inDeeperSleep, .extendedActive);
   // ****************
   // Helpers
   // ****************
   always #50 freeClk = !freeClk;
   // Watchdog counts free clocks, since the bus clock may be stopped.
   always @(posedge freeClk) if (++cycles > 3000) begin
      num_errors++;
      print_verdict();
   end
   function automatic logic expExt(int st, logic h, logic pH, logic pS, logic pD);
      return h || (st == 0 && pH) || (st == 1 && pS) || (st == 2 && pD);
   endfunction
   task automatic chk(string what, logic [6:0] exp, logic [6:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("Compares %0d, errors %0d.", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   // Every state kind, promotion set, hard option and clock stop are visited.
   initial begin
      void'($urandom(10062));
      repeat (4) @(negedge freeClk);
      sys_rst = 1'h0;
      goDeep = 1'h1;
      repeat (6) @(negedge freeClk);
      chk("inDeepSleep", 7'h0, 7'(inDeepSleep));
      goDeep = 1'h0;
      for (int i = 0; i < 6; i++) begin
         requestedPstate = 4'($urandom_range(15, 1));
         {subStateHint, promoteHalt, promoteStopGrant, promoteDeeper} = i == 1 ? 4'h0 : 4'($urandom);
         {stopClk, hardOpt} = 2'(i);
         repeat (70) @(negedge freeClk);
         chk("pstate", 7'(requestedPstate), 7'(currentPstate));
         lowPowerState = dss_pkg::dss_cstate_type'(i % 3);
         e = expExt(i % 3, subStateHint, promoteHalt, promoteStopGrant, promoteDeeper);
         lowPowerReq = 1'h1;
         for (n = 0; n < 20 && executing !== 1'h0; n++) @(negedge freeClk);
         lowPowerReq = 1'h0;
         repeat (3) @(negedge freeClk);
         chk("extended", 7'(e), 7'(extendedActive));
         chk("pstate", e ? 7'h0 : 7'(requestedPstate), 7'(currentPstate));
         {sleepEnter, goDeep} = 2'h3;
         for (n = 0; n < 20 && inDeepSleep !== 1'h1; n++) @(negedge freeClk);
         goDeeper = 1'h1;
         for (n = 0; n < 20 && inDeeperSleep !== 1'h1; n++) @(negedge freeClk);
         chk("vid", deeperVid, voltage_id_code);
         repeat (8) @(negedge freeClk);
         goDeeper = 1'h0;
         for (n = 0; n < 20 && inDeeperSleep !== 1'h0; n++) @(negedge freeClk);
         repeat (2) @(negedge freeClk);
         chk("pstate", (e | hardOpt) ? 7'h0 : 7'(requestedPstate), 7'(currentPstate));
         if (hardOpt) chk("vid", lowestVid, voltage_id_code);
         {goDeep, sleepEnter, breakEvent} = 3'h1;
         for (n = 0; n < 20 && executing !== 1'h1; n++) @(negedge freeClk);
         chk("resumed", 7'h1, 7'(n < 8));
         breakEvent = 1'h0;
      end
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- verilog/dss_pkg.sv ----
// Constants and types for the deep sleep state sequencer.
// Assumes a single bus clock domain; the bus clock may stop during deep sleep.
//
// Functional notes
// - Deep sleep entered only when deep sleep request asserts while in sleep.
// - Deep sleep behaves as deeper sleep except for voltage; only deeper sleep drives the deeper sleep code (code changes to the lowest code at exit).
// - Device works in deep sleep whether bus clock runs or stops.
// - Deeper sleep entered only when deeper request asserts while in deep sleep.
// - Entering deeper sleep drives the deeper sleep voltage identification code.
// - Deeper sleep exit begins when the deeper sleep request deasserts.
// - Extended state first steps performance down to lowest point, then enters.
// - Break from extended state resumes execution at once, raising performance.
// - Extended requests come from idle hints or promotion configuration bits.
// - No multi-step performance transitions in sleep or deep sleep, except hard option.
// - Hard option lowers core voltage to deeper sleep level in deeper sleep.
// - Hard option exits deeper sleep to lowest operating point automatically.

`default_nettype none

package dss_pkg;

   // ************************************************************
   // Widths and codes
   // ************************************************************
   localparam int VID_W = 7;
   localparam int PSTATE_W = 4;
   localparam logic [PSTATE_W-1:0] PSTATE_LOWEST = 4'h0;
   localparam logic [PSTATE_W-1:0] PSTATE_RESET = 4'h0;
   localparam logic [VID_W-1:0] VID_RESET = 7'h00;
   // Cycles taken by one performance step; one step moves one operating point.
   localparam logic [3:0] STEP_CYCLES = 4'h4;

   // Low-power state requested by the core.
   typedef enum logic [1:0] {
      CST_HALT,
      CST_STOP_GRANT,
      CST_DEEPER
   } dss_cstate_type;

   typedef enum {
      ST_ACTIVE,
      ST_STEP_DOWN,
      ST_LOW,
      ST_SLEEP,
      ST_DEEP,
      ST_DEEPER
   } dss_state_type;

endpackage

`default_nettype wire

// ---- verilog/dss_sequencer.sv ----
// Deep and deeper sleep sequencer with extended low-power state handling.
// Assumes the chipset drives the two active-low request pins synchronously to mclk,
// and that mclk may stop while in deep or deeper sleep.

`default_nettype none

module dss_sequencer (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic lowPowerReq,
   input wire dss_pkg::dss_cstate_type lowPowerState,
   input wire logic subStateHint,
   input wire logic promoteHalt,
   input wire logic promoteStopGrant,
   input wire logic promoteDeeper,
   input wire logic hard_extended_deeper_sleep_option,
   input wire logic breakEvent,
   input wire logic sleepEnter,
   input wire logic deep_sleep_req_n,
   input wire logic deeper_sleep_req_n,
   input wire logic [dss_pkg::PSTATE_W-1:0] requestedPstate,
   input wire logic [dss_pkg::VID_W-1:0] activeVid,
   input wire logic [dss_pkg::VID_W-1:0] lowestVid,
   input wire logic [dss_pkg::VID_W-1:0] deeperVid,
   output logic [dss_pkg::VID_W-1:0] voltage_id_code,
   output logic [dss_pkg::PSTATE_W-1:0] currentPstate,
   output logic executing,
   output logic inDeepSleep,
   output logic inDeeperSleep,
   output logic extendedActive
);

   // ************************************************************
   // State
   // ************************************************************
   dss_pkg::dss_state_type state_reg;
   logic extended_reg;
   logic [dss_pkg::PSTATE_W-1:0] pstate_reg;
   logic [dss_pkg::PSTATE_W-1:0] target_reg;
   logic [3:0] stepCnt_reg;
   logic [dss_pkg::VID_W-1:0] vid_reg;
   logic extendedReq;
   logic stepping;
   logic atTarget;

   // Decides whether a request is extended, from a hint or a promotion bit.
   function automatic logic isExtended(input dss_pkg::dss_cstate_type cs, input logic hint,
         input logic pH, input logic pS, input logic pD);
      logic promo;
      promo = 1'b0;
      unique case (cs)
         dss_pkg::CST_HALT: promo = pH;
         dss_pkg::CST_STOP_GRANT: promo = pS;
         dss_pkg::CST_DEEPER: promo = pD;
      endcase
      return hint | promo;
   endfunction

   assign extendedReq = isExtended(lowPowerState, subStateHint, promoteHalt,
                                   promoteStopGrant, promoteDeeper);

   // Stepping is allowed only in ST_ACTIVE and ST_STEP_DOWN; ST_LOW and the sleep states freeze it.
   // no stepping asleep
   assign stepping = (state_reg == dss_pkg::ST_ACTIVE) || (state_reg == dss_pkg::ST_STEP_DOWN);
   assign atTarget = (pstate_reg == target_reg);

   // ************************************************************
   // Sleep sequencing
   // ************************************************************
   // Deep sleep and deeper sleep are separate states: both stop the core, only the voltage differs.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= dss_pkg::ST_ACTIVE;
         extended_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            dss_pkg::ST_ACTIVE: begin
               if (lowPowerReq) begin
                  extended_reg <= extendedReq;
                  state_reg <= extendedReq ? dss_pkg::ST_STEP_DOWN : dss_pkg::ST_LOW;
               end
            end
            dss_pkg::ST_STEP_DOWN: begin
               if (breakEvent) begin
                  state_reg <= dss_pkg::ST_ACTIVE;
               end else if (pstate_reg == dss_pkg::PSTATE_LOWEST) begin
                  state_reg <= dss_pkg::ST_LOW;
               end
            end
            dss_pkg::ST_LOW: begin
               if (breakEvent) begin
                  state_reg <= dss_pkg::ST_ACTIVE;
               end else if (sleepEnter) begin
                  state_reg <= dss_pkg::ST_SLEEP;
               end
            end
            dss_pkg::ST_SLEEP: begin
               if (!deep_sleep_req_n) begin
                  state_reg <= dss_pkg::ST_DEEP;
               end else if (!sleepEnter) begin
                  state_reg <= dss_pkg::ST_LOW;
               end
            end
            dss_pkg::ST_DEEP: begin
               if (!deeper_sleep_req_n) begin
                  state_reg <= dss_pkg::ST_DEEPER;
               end else if (deep_sleep_req_n) begin
                  state_reg <= dss_pkg::ST_SLEEP;
               end
            end
            dss_pkg::ST_DEEPER: begin
               if (deeper_sleep_req_n) begin
                  state_reg <= dss_pkg::ST_DEEP;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Performance state stepping
   // ************************************************************
   // Target is lowest while an extended entry or a hard-option exit is pending.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         target_reg <= dss_pkg::PSTATE_RESET;
      end else if (state_reg == dss_pkg::ST_DEEPER && deeper_sleep_req_n
            && hard_extended_deeper_sleep_option) begin
         target_reg <= dss_pkg::PSTATE_LOWEST;
      end else if (state_reg == dss_pkg::ST_STEP_DOWN && !breakEvent) begin
         target_reg <= dss_pkg::PSTATE_LOWEST;
      end else if (state_reg == dss_pkg::ST_ACTIVE) begin
         target_reg <= requestedPstate;
      end
   end

   // One operating point per STEP_CYCLES in ST_ACTIVE so the voltage can settle; ST_STEP_DOWN and the hard-option exit go to lowest in one cycle.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pstate_reg <= dss_pkg::PSTATE_RESET;
         stepCnt_reg <= 4'h0;
      end else if (state_reg == dss_pkg::ST_DEEPER && deeper_sleep_req_n
            && hard_extended_deeper_sleep_option) begin
         // exit to lowest
         // The hard option is the one case allowed to move the point outside the active states.
         pstate_reg <= dss_pkg::PSTATE_LOWEST;
         stepCnt_reg <= 4'h0;
      end else if (state_reg == dss_pkg::ST_STEP_DOWN) begin
         pstate_reg <= dss_pkg::PSTATE_LOWEST;
         stepCnt_reg <= 4'h0;
      end else if (stepping && !atTarget) begin
         if (stepCnt_reg == dss_pkg::STEP_CYCLES - 4'h1) begin
            stepCnt_reg <= 4'h0;
            pstate_reg <= (pstate_reg < target_reg) ? pstate_reg + 4'h1 : pstate_reg - 4'h1;
         end else begin
            stepCnt_reg <= stepCnt_reg + 4'h1;
         end
      end else begin
         stepCnt_reg <= 4'h0;
      end
   end

   // ************************************************************
   // Voltage identification
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         vid_reg <= dss_pkg::VID_RESET;
      end else if (state_reg == dss_pkg::ST_DEEPER && !deeper_sleep_req_n) begin
         vid_reg <= deeperVid;
      end else if (state_reg == dss_pkg::ST_DEEPER
            || (state_reg != dss_pkg::ST_ACTIVE && pstate_reg == dss_pkg::PSTATE_LOWEST)) begin
         vid_reg <= lowestVid;
      end else if (state_reg == dss_pkg::ST_ACTIVE || state_reg == dss_pkg::ST_STEP_DOWN) begin
         vid_reg <= (pstate_reg == dss_pkg::PSTATE_LOWEST) ? lowestVid : activeVid;
      end
   end

   // Status outputs are registered copies so every output comes from a flip-flop.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         executing <= 1'b1;
         inDeepSleep <= 1'b0;
         inDeeperSleep <= 1'b0;
         extendedActive <= 1'b0;
      end else begin
         executing <= (state_reg == dss_pkg::ST_ACTIVE);
         inDeepSleep <= (state_reg == dss_pkg::ST_DEEP) || (state_reg == dss_pkg::ST_DEEPER);
         inDeeperSleep <= (state_reg == dss_pkg::ST_DEEPER);
         extendedActive <= extended_reg && (state_reg != dss_pkg::ST_ACTIVE);
      end
   end

   assign voltage_id_code = vid_reg;
   assign currentPstate = pstate_reg;

endmodule

`default_nettype wire
